// [rms_pkg.sv]
// package: register map, reset values and codes of the reference monitor status block
package rms_pkg;
   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_INPUT_FAIL_STATUS = 8'h02;
   localparam logic [7:0] IDX_LOOP_EVENT_FLAGS = 8'h03;
   localparam logic [7:0] IDX_MONITOR_FAIL_FLAGS_A = 8'h05;
   localparam logic [7:0] IDX_MONITOR_FAIL_FLAGS_B = 8'h06;
   localparam logic [7:0] IDX_INPUT_FAIL_IRQ_ENABLE = 8'h09;
   localparam logic [7:0] IDX_LOOP_EVENT_IRQ_ENABLE = 8'h0a;
   localparam logic [7:0] IDX_MONITOR_ENABLE_A = 8'h0c;
   localparam logic [7:0] IDX_MONITOR_ENABLE_B = 8'h0d;
   localparam logic [7:0] IDX_INPUT_RATE_CODES_A = 8'h10;
   localparam logic [7:0] IDX_INPUT_RATE_CODES_B = 8'h11;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_INPUT_FAIL_STATUS = 8'hff;
   localparam logic [7:0] RST_LOOP_EVENT_FLAGS = 8'h70;
   localparam logic [7:0] RST_MONITOR_FAIL_FLAGS = 8'h00;
   localparam logic [7:0] RST_INPUT_FAIL_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RST_LOOP_EVENT_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RST_MONITOR_ENABLE = 8'hff;
   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int LOOP_LOCKED_BIT = 0;
   localparam int LOOP_LOST_LOCK_BIT = 1;
   localparam int LOOP_HOLDOVER_BIT = 2;
   localparam int LOOP_REF_CHANGED_BIT = 3;
   localparam int LOOP_SYNC_FAIL_LSB = 4;
   localparam logic [7:0] LOOP_EVENT_USED = 8'h7f;
   localparam logic [7:0] INPUT_FAIL_USED = 8'h07;
   localparam int MON_PER_INPUT = 4;
   // ------------------------------------------------------------
   // detected rate codes
   // ------------------------------------------------------------
   localparam logic [3:0] RATE_2KHZ = 4'h0;
   localparam logic [3:0] RATE_1544KHZ = 4'h3;
   localparam logic [3:0] RATE_77760KHZ = 4'ha;
   localparam logic [3:0] RATE_UNKNOWN = 4'hf;
endpackage

// [rms_regs.sv]
// module: loop event, monitor failure and interrupt enable registers on apb
`timescale 1ns/1ps
`default_nettype none
// Operation
// - loop event bit 3 sets on reference switch, clears on read.
// - loop event bits 6:4 set on frame-sync input 0..2 failure, clear on read.
// - monitor flags: cycle, coarse, guard, precise; inputs 0,1 in A, input 2 in B.
// - monitor flag reads 1 on failure, is sticky; B bits 7:4 stay default.
// - input fail enable resets 0x00; bits 0..2 gate input 0..2 failure interrupt.
// - loop event enable resets 0x00, bits 6:0 enable matching event bits.
// - monitor enables reset 0xff; a zero suppresses that failure indicator.
// - read-only 4-bit rate code per input: 0 and 1 in A, 2 in B low.
// - rate codes 0000 for 2 kHz up to 1010 for 77.76 MHz.
// - code 1111 reported until that input's rate is identified.
// - loop event bits 0,1,2 set on lock, lock loss, holdover; clear on read.
// - input fail status bits 0..2 show input failure; resets all ones.
module rms_regs #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lock_acquired,
   input wire logic lock_lost,
   input wire logic holdover_entered,
   input wire logic ref_switched,
   input wire logic [2:0] sync_fail_detected,
   input wire logic [11:0] monitor_fail_detected,
   input wire logic [2:0] input_fail,
   input wire logic [11:0] input_rate_code,
   input wire logic [2:0] input_rate_known,
   output logic irq
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] rate_field(input logic known, input logic [3:0] code);
      // codes past the top rate are treated as not yet identified
      if (known && code <= rms_pkg::RATE_77760KHZ) begin
         rate_field = code;
      end else begin
         rate_field = rms_pkg::RATE_UNKNOWN;
      end
   endfunction

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = 8'(a >> 2);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] loop_flags_r, loop_flags_nxt;
   logic [7:0] input_fail_r, input_fail_nxt;
   logic [7:0] mon_a_r, mon_a_nxt;
   logic [7:0] mon_b_r, mon_b_nxt;
   logic [7:0] fail_en_r, fail_en_nxt;
   logic [7:0] loop_en_r, loop_en_nxt;
   logic [7:0] mon_en_a_r, mon_en_a_nxt;
   logic [7:0] mon_en_b_r, mon_en_b_nxt;
   logic [7:0] rate_a_r, rate_a_nxt;
   logic [7:0] rate_b_r, rate_b_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic irq_r, irq_nxt;

   logic setup, done, rd_done, wr_done, hit, word_ok;
   logic [7:0] idx, idx_q, rd_val;
   logic [ADDR_W-1:0] paddr_q;
   logic [11:0] mon_set, mon_clr;
   logic [7:0] loop_set, loop_clr;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   // answer is formed in the setup cycle so data comes from a flop
   assign setup = psel && !penable;
   assign done = psel && penable && pready_r;
   assign rd_done = done && !pwrite && !pslverr_r;
   assign wr_done = done && pwrite && !pslverr_r;
   assign idx = reg_index(paddr);
   assign paddr_q = paddr;
   assign idx_q = reg_index(paddr_q);
   assign word_ok = (paddr[1:0] == 2'b00);

   always_comb begin
      hit = word_ok;
      rd_val = 8'h00;
      unique case (idx)
         rms_pkg::IDX_INPUT_FAIL_STATUS: rd_val = input_fail_r;
         rms_pkg::IDX_LOOP_EVENT_FLAGS: rd_val = loop_flags_r;
         rms_pkg::IDX_MONITOR_FAIL_FLAGS_A: rd_val = mon_a_r;
         rms_pkg::IDX_MONITOR_FAIL_FLAGS_B: rd_val = mon_b_r;
         rms_pkg::IDX_INPUT_FAIL_IRQ_ENABLE: rd_val = fail_en_r;
         rms_pkg::IDX_LOOP_EVENT_IRQ_ENABLE: rd_val = loop_en_r;
         rms_pkg::IDX_MONITOR_ENABLE_A: rd_val = mon_en_a_r;
         rms_pkg::IDX_MONITOR_ENABLE_B: rd_val = mon_en_b_r;
         rms_pkg::IDX_INPUT_RATE_CODES_A: rd_val = rate_a_r;
         rms_pkg::IDX_INPUT_RATE_CODES_B: rd_val = rate_b_r;
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      pready_nxt = 1'b0;
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      if (setup) begin
         pready_nxt = 1'b1;
         prdata_nxt = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
         pslverr_nxt = !hit;
      end
   end

   // ------------------------------------------------------------
   // event and sticky flags
   // ------------------------------------------------------------
   // only bits actually returned are cleared, so an event landing
   // between setup and access is kept for the next read
   always_comb begin
      loop_set = 8'h00;
      loop_set[rms_pkg::LOOP_LOCKED_BIT] = lock_acquired;
      loop_set[rms_pkg::LOOP_LOST_LOCK_BIT] = lock_lost;
      loop_set[rms_pkg::LOOP_HOLDOVER_BIT] = holdover_entered;
      loop_set[rms_pkg::LOOP_REF_CHANGED_BIT] = ref_switched;
      loop_set[rms_pkg::LOOP_SYNC_FAIL_LSB +: 3] = sync_fail_detected;
      loop_clr = 8'h00;
      if (rd_done && idx_q == rms_pkg::IDX_LOOP_EVENT_FLAGS) begin
         loop_clr = prdata_r[7:0];
      end
      // set wins over read clear; bit 7 never moves
      loop_flags_nxt = ((loop_flags_r & ~loop_clr) | loop_set)
         & rms_pkg::LOOP_EVENT_USED;
   end

   always_comb begin
      // a disabled monitor never raises its flag
      mon_set = monitor_fail_detected & {mon_en_b_r[3:0], mon_en_a_r};
      mon_clr = 12'h000;
      if (rd_done && idx_q == rms_pkg::IDX_MONITOR_FAIL_FLAGS_A) begin
         mon_clr[7:0] = prdata_r[7:0];
      end
      if (rd_done && idx_q == rms_pkg::IDX_MONITOR_FAIL_FLAGS_B) begin
         mon_clr[11:8] = prdata_r[3:0];
      end
      // sticky until read, set wins
      mon_a_nxt = (mon_a_r & ~mon_clr[7:0]) | mon_set[7:0];
      mon_b_nxt = {4'h0, (mon_b_r[3:0] & ~mon_clr[11:8]) | mon_set[11:8]};
      input_fail_nxt = (rms_pkg::RST_INPUT_FAIL_STATUS & ~rms_pkg::INPUT_FAIL_USED)
         | {5'h00, input_fail};
      rate_a_nxt = {rate_field(input_rate_known[1], input_rate_code[7:4]),
         rate_field(input_rate_known[0], input_rate_code[3:0])};
      rate_b_nxt = {4'h0, rate_field(input_rate_known[2], input_rate_code[11:8])};
   end

   // ------------------------------------------------------------
   // enable registers
   // ------------------------------------------------------------
   always_comb begin
      fail_en_nxt = fail_en_r;
      loop_en_nxt = loop_en_r;
      mon_en_a_nxt = mon_en_a_r;
      mon_en_b_nxt = mon_en_b_r;
      if (wr_done && pstrb[0]) begin
         unique case (idx_q)
            rms_pkg::IDX_INPUT_FAIL_IRQ_ENABLE: fail_en_nxt = pwdata[7:0];
            rms_pkg::IDX_LOOP_EVENT_IRQ_ENABLE: begin
               loop_en_nxt = pwdata[7:0] & rms_pkg::LOOP_EVENT_USED;
            end
            rms_pkg::IDX_MONITOR_ENABLE_A: mon_en_a_nxt = pwdata[7:0];
            rms_pkg::IDX_MONITOR_ENABLE_B: mon_en_b_nxt = pwdata[7:0];
            default: fail_en_nxt = fail_en_r;
         endcase
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   always_comb begin
      irq_nxt = (|(loop_flags_r & loop_en_r))
         || (|(input_fail_r & fail_en_r & rms_pkg::INPUT_FAIL_USED));
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_flags_r <= rms_pkg::RST_LOOP_EVENT_FLAGS;
         input_fail_r <= rms_pkg::RST_INPUT_FAIL_STATUS;
         mon_a_r <= rms_pkg::RST_MONITOR_FAIL_FLAGS;
         mon_b_r <= rms_pkg::RST_MONITOR_FAIL_FLAGS;
         fail_en_r <= rms_pkg::RST_INPUT_FAIL_IRQ_ENABLE;
         loop_en_r <= rms_pkg::RST_LOOP_EVENT_IRQ_ENABLE;
         mon_en_a_r <= rms_pkg::RST_MONITOR_ENABLE;
         mon_en_b_r <= rms_pkg::RST_MONITOR_ENABLE;
         rate_a_r <= {rms_pkg::RATE_UNKNOWN, rms_pkg::RATE_UNKNOWN};
         rate_b_r <= {4'h0, rms_pkg::RATE_UNKNOWN};
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
      end else if (pce) begin
         loop_flags_r <= loop_flags_nxt;
         input_fail_r <= input_fail_nxt;
         mon_a_r <= mon_a_nxt;
         mon_b_r <= mon_b_nxt;
         fail_en_r <= fail_en_nxt;
         loop_en_r <= loop_en_nxt;
         mon_en_a_r <= mon_en_a_nxt;
         mon_en_b_r <= mon_en_b_nxt;
         rate_a_r <= rate_a_nxt;
         rate_b_r <= rate_b_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ref_change;
      pce && ref_switched |=> loop_flags_r[3];
   endproperty
   a_ref_change: assert property (p_ref_change) else $error("ref change flag missed");

   property p_sync_fail;
      pce && sync_fail_detected[2] |=> loop_flags_r[6];
   endproperty
   a_sync_fail: assert property (p_sync_fail) else $error("sync fail flag missed");

   property p_read_clear;
      pce && rd_done && idx_q == rms_pkg::IDX_LOOP_EVENT_FLAGS && prdata_r[0]
         && !lock_acquired |=> !loop_flags_r[0];
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("locked flag not cleared");

   property p_mon_set;
      pce && monitor_fail_detected[9] && mon_en_b_r[1] |=> mon_b_r[1] ##1 (mon_b_r[1] || $past(rd_done));
   endproperty
   a_mon_set: assert property (p_mon_set) else $error("monitor flag not sticky");

   property p_mon_upper;
      mon_b_r[7:4] == 4'h0;
   endproperty
   a_mon_upper: assert property (p_mon_upper) else $error("monitor b upper bits moved");

   property p_mon_masked;
      pce && !mon_en_a_r[0] && !mon_a_r[0] |=> !mon_a_r[0];
   endproperty
   a_mon_masked: assert property (p_mon_masked) else $error("disabled monitor flagged");

   property p_fail_en_write;
      pce && wr_done && pstrb[0] && idx_q == rms_pkg::IDX_INPUT_FAIL_IRQ_ENABLE
         |=> fail_en_r == $past(pwdata[7:0]);
   endproperty
   a_fail_en_write: assert property (p_fail_en_write) else $error("fail enable write lost");

   property p_irq_on;
      pce && input_fail[0] && fail_en_r[0] ##1 pce && fail_en_r[0] |=> irq_r;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");

   property p_input_fail;
      pce && input_fail[1] |=> input_fail_r[1] && input_fail_r[7:3] == 5'h1f;
   endproperty
   a_input_fail: assert property (p_input_fail) else $error("input fail status wrong");

   property p_rate_unknown;
      pce && !input_rate_known[2] |=> rate_b_r == 8'h0f;
   endproperty
   a_rate_unknown: assert property (p_rate_unknown) else $error("unknown rate not 1111");

   property p_reserved_loop;
      !loop_flags_r[7] && !loop_en_r[7];
   endproperty
   a_reserved_loop: assert property (p_reserved_loop) else $error("loop bit 7 moved");

   property p_loop_en_write;
      pce && wr_done && pstrb[0] && idx_q == rms_pkg::IDX_LOOP_EVENT_IRQ_ENABLE
         |=> loop_en_r == ($past(pwdata[7:0]) & 8'h7f);
   endproperty
   a_loop_en_write: assert property (p_loop_en_write) else $error("loop enable write lost");
endmodule
`default_nettype wire

// [tb_rms_regs.sv]
// testbench: register map, read-clear, sticky flags, enables and irq of rms_regs
`timescale 1ns/1ps
`default_nettype none
module tb_rms_regs;
   logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb;
   logic lock_acquired, lock_lost, holdover_entered, ref_switched, e;
   logic [2:0] sync_fail_detected, input_fail, input_rate_known;
   logic [11:0] monitor_fail_detected, input_rate_code;
   int mismatches, compares, lf, mf, men, len, fen, inf, c, k, v;
   rms_regs #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lock_acquired(lock_acquired),
      .lock_lost(lock_lost), .holdover_entered(holdover_entered), .ref_switched(ref_switched),
      .sync_fail_detected(sync_fail_detected), .monitor_fail_detected(monitor_fail_detected),
      .input_fail(input_fail), .input_rate_code(input_rate_code),
      .input_rate_known(input_rate_known), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask
   // no local limit: only the watchdog ends a wait for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] i, input int d);
      apb(1'b1, {i[5:0], 2'b00}, d, 4'hf);
   endtask
   task automatic rd(input logic [7:0] i, input int x, input string nm);
      apb(1'b0, {i[5:0], 2'b00}, 32'h0, 4'hf);
      chk(nm, r, x);
      chk("pslverr", {31'h0, e}, 32'h0);
   endtask
   // one-cycle event pulses, then time for status and irq to settle
   task automatic ev(input logic [6:0] le, input logic [11:0] mon);
      @(posedge pclk);
      {sync_fail_detected, ref_switched, holdover_entered, lock_lost, lock_acquired} <= le;
      monitor_fail_detected <= mon;
      @(posedge pclk);
      {sync_fail_detected, ref_switched, holdover_entered, lock_lost, lock_acquired} <= 7'h0;
      monitor_fail_detected <= 12'h0;
      repeat (3) @(posedge pclk);
      lf |= le;
      mf |= mon & men;
   endtask
   task automatic irq_chk();
      chk("irq", {31'h0, irq}, ((lf & len & 8'hff) != 0 || (inf & fen & 7) != 0));
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      #1ms;
      mismatches++;
      finish_test();
   end
   initial begin
      presetn = 1'b0; pce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h0; pwdata = 32'h0; pstrb = 4'h0; {lock_acquired, lock_lost} = 2'b00;
      {holdover_entered, ref_switched} = 2'b00; sync_fail_detected = 3'h0;
      monitor_fail_detected = 12'h0; input_fail = 3'h7; input_rate_code = 12'h0;
      input_rate_known = 3'h0;
      lf = 8'h70; mf = 0; men = 12'hfff; len = 0; fen = 0; inf = 7;
      v = $urandom(32'h9d4098b5);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(rms_pkg::IDX_INPUT_FAIL_STATUS, 8'hff, "fail status");
      rd(rms_pkg::IDX_MONITOR_FAIL_FLAGS_A, 0, "mon flags a");
      rd(rms_pkg::IDX_MONITOR_FAIL_FLAGS_B, 0, "mon flags b");
      rd(rms_pkg::IDX_INPUT_FAIL_IRQ_ENABLE, 8'h00, "fail en");
      rd(rms_pkg::IDX_LOOP_EVENT_IRQ_ENABLE, 8'h00, "loop en");
      rd(rms_pkg::IDX_MONITOR_ENABLE_A, 8'hff, "mon en a");
      rd(rms_pkg::IDX_MONITOR_ENABLE_B, 8'hff, "mon en b");
      rd(rms_pkg::IDX_INPUT_RATE_CODES_A, 8'hff, "rate a");
      rd(rms_pkg::IDX_INPUT_RATE_CODES_B, 8'h0f, "rate b");
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         len = $urandom & 8'h7f;
         fen = $urandom & 8'hff;
         inf = $urandom & 3'h7;
         wr(rms_pkg::IDX_LOOP_EVENT_IRQ_ENABLE, len);
         wr(rms_pkg::IDX_INPUT_FAIL_IRQ_ENABLE, fen);
         input_fail <= inf[2:0];
         repeat (3) @(posedge pclk);
         irq_chk();
         rd(rms_pkg::IDX_INPUT_FAIL_STATUS, 8'hf8 | inf, "fail status");
         rd(rms_pkg::IDX_LOOP_EVENT_IRQ_ENABLE, len, "loop en");
         rd(rms_pkg::IDX_INPUT_FAIL_IRQ_ENABLE, fen, "fail en");
      end
      len = 8'h7f;
      wr(rms_pkg::IDX_LOOP_EVENT_IRQ_ENABLE, len);
      rd(rms_pkg::IDX_LOOP_EVENT_FLAGS, lf, "loop flags");
      lf = 0;
      $display("test irq enables done");
      for (int b = 0; b < 7; b++) begin
         ev(7'h1 << b, 12'h0);
         irq_chk();
         rd(rms_pkg::IDX_LOOP_EVENT_FLAGS, 1 << b, "loop flag set");
         lf = 0;
         rd(rms_pkg::IDX_LOOP_EVENT_FLAGS, 0, "loop flag clear");
      end
      // refused accesses must not clear the flags
      ev(7'h7f, 12'h0);
      apb(1'b0, 8'h1c, 32'h0, 4'hf);
      chk("unmapped err", {31'h0, e}, 32'h1);
      apb(1'b0, 8'h0d, 32'h0, 4'hf);
      chk("misaligned err", {31'h0, e}, 32'h1);
      rd(rms_pkg::IDX_LOOP_EVENT_FLAGS, lf, "loop flags kept");
      lf = 0;
      // events while the clock enable is low are not seen
      pce <= 1'b0;
      ev(7'h08, 12'h0);
      pce <= 1'b1;
      lf = 0;
      rd(rms_pkg::IDX_LOOP_EVENT_FLAGS, 0, "frozen flags");
      $display("test loop events done");
      for (int i = 0; i < 5; i++) begin
         men = (i == 0) ? 12'hfff : ($urandom & 12'hfff);
         wr(rms_pkg::IDX_MONITOR_ENABLE_A, men & 8'hff);
         wr(rms_pkg::IDX_MONITOR_ENABLE_B, 8'hf0 | (men >> 8));
         apb(1'b1, {rms_pkg::IDX_MONITOR_ENABLE_A[5:0], 2'b00}, 32'h0, 4'h0);
         rd(rms_pkg::IDX_MONITOR_ENABLE_A, men & 8'hff, "mon en a");
         rd(rms_pkg::IDX_MONITOR_ENABLE_B, 8'hf0 | (men >> 8), "mon en b");
         ev(7'h0, $urandom & 12'hfff);
         ev(7'h0, 12'h0);
         rd(rms_pkg::IDX_MONITOR_FAIL_FLAGS_A, mf & 8'hff, "mon flags a");
         rd(rms_pkg::IDX_MONITOR_FAIL_FLAGS_B, mf >> 8, "mon flags b");
         mf = 0;
      end
      $display("test monitor flags done");
      for (int j = 0; j < 16; j++) begin
         k = (j == 0) ? 0 : (j < 12 ? 7 : $urandom & 7);
         input_rate_code <= {4'(j + 2), 4'(j + 1), 4'(j)};
         input_rate_known <= k[2:0];
         repeat (3) @(posedge pclk);
         v = 0;
         for (int i = 0; i < 3; i++) begin
            c = (j + i) % 16;
            v |= ((k >> i & 1) && c <= 10 ? c : 15) << (4 * i);
         end
         wr(rms_pkg::IDX_INPUT_RATE_CODES_A, 8'h5a);
         rd(rms_pkg::IDX_INPUT_RATE_CODES_A, v & 8'hff, "rate a");
         rd(rms_pkg::IDX_INPUT_RATE_CODES_B, v >> 8, "rate b");
      end
      $display("test rate codes done");
      finish_test();
   end
endmodule
`default_nettype wire
